// File: ssf_pkg.sv
// Purpose: constants, register map and types for the system status flag bank
// Assumes: one 250 MHz clock, APB slave with 32-bit data
// Notes: all flags are gathered into bus registers at fixed word offsets
package ssf_pkg;
  // ==========================================================
  // register map, byte addresses
  localparam logic [11:0] SSF_OFF_STICKY = 12'h000;
  localparam logic [11:0] SSF_OFF_LIVE = 12'h004;
  localparam logic [11:0] SSF_OFF_CTRL = 12'h008;
  localparam logic [11:0] SSF_OFF_IRQ_STAT = 12'h00C;
  localparam logic [11:0] SSF_OFF_IRQ_MASK = 12'h010;
  localparam logic [11:0] SSF_OFF_CLK_W0 = 12'h014;
  localparam logic [11:0] SSF_OFF_CLK_W1 = 12'h018;
  localparam logic [11:0] SSF_OFF_CLK_W2 = 12'h01C;
  localparam logic [11:0] SSF_OFF_CLK_W3 = 12'h020;
  // ==========================================================
  // field positions
  localparam int SSF_B_DIAG = 0;
  localparam int SSF_B_SELF = 1;
  localparam int SSF_B_BLOW = 2;
  localparam int SSF_B_BWARN = 3;
  localparam int SSF_B_DROP = 4;
  localparam int SSF_B_FUSE = 5;
  localparam int SSF_NSTICKY = 6;
  localparam int SSF_CTRL_MERR = 0;
  localparam int SSF_CTRL_CREQ = 1;
  localparam int SSF_NCPU = 4;
  localparam logic [5:0] SSF_STICKY_RST = 6'h00;
  localparam logic [31:0] SSF_ZERO = 32'h0000_0000;
  // clock word legal ranges (bcd-free binary: month/day, hour/min, sec/dow)
  localparam logic [7:0] SSF_MON_MAX = 8'h0C;
  localparam logic [7:0] SSF_DAY_MAX = 8'h1F;
  localparam logic [7:0] SSF_HOUR_MAX = 8'h17;
  localparam logic [7:0] SSF_MIN_MAX = 8'h3B;
  localparam logic [7:0] SSF_SEC_MAX = 8'h3B;
  localparam logic [7:0] SSF_DOW_MAX = 8'h06;
  localparam logic [7:0] SSF_ONE = 8'h01;

  // condition inputs
  typedef struct packed {
    logic diag_err;
    logic self_diag_err;
    logic batt_below_2v5;
    logic batt_below_2v7;
    logic ac_dropout;
    logic fuse_blown_any;
  } ssf_cond_t;

  typedef struct packed {
    logic [15:0] w3;
    logic [15:0] w2;
    logic [15:0] w1;
    logic [15:0] w0;
  } ssf_clkw_t;
endpackage : ssf_pkg

// File: ssf_sync.sv
// Purpose: two-flop synchroniser for asynchronous condition inputs
// Assumes: inputs are slow levels
// Notes: first stage is read only by second stage
`timescale 1ns/1ps
module ssf_sync
  import ssf_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // ==========================================================
  // synchroniser chain
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : ssf_sync

// File: ssf_clkchk.sv
// Purpose: validity check of stored clock data words w1 to w3; the year word w0 is not checked
// Assumes: w0 year, w1 month/day, w2 hour/minute, w3 second/weekday
// Notes: purely combinational, one bit out
`timescale 1ns/1ps
module ssf_clkchk
  import ssf_pkg::*;
(
  input wire ssf_clkw_t words,
  output logic bad
);
  // range test shared by all six checked fields
  function automatic logic out_of(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    out_of = (v < lo) || (v > hi);
  endfunction : out_of

  // ==========================================================
  // any field outside its legal range marks the set invalid
  always_comb
  begin
    bad = out_of(words.w1[15:8], SSF_ONE, SSF_MON_MAX)
       || out_of(words.w1[7:0], SSF_ONE, SSF_DAY_MAX)
       || out_of(words.w2[15:8], 8'h00, SSF_HOUR_MAX)
       || out_of(words.w2[7:0], 8'h00, SSF_MIN_MAX)
       || out_of(words.w3[15:8], 8'h00, SSF_SEC_MAX)
       || out_of(words.w3[7:0], 8'h00, SSF_DOW_MAX);
  end
endmodule : ssf_clkchk

// File: ssf_bank.sv
// Purpose: system status flag bank with APB register access and interrupt
// Assumes: single clock, async active-high power-on reset
// Notes: only sys_rst clears the supply dropout latch
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ssf_bank
  import ssf_pkg::*;
#(
  parameter int NCPU = SSF_NCPU
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ssf_cond_t cond_in,
  input wire logic [NCPU-1:0] cpu_ready_in,
  input wire logic cpu1_reset_in,
  output logic diag_error_flag,
  output logic self_diag_error_flag,
  output logic batt_low_latch,
  output logic batt_low_live,
  output logic batt_warn_latch,
  output logic batt_warn_live,
  output logic supply_dropout_flag,
  output logic fuse_blown_flag,
  output logic clock_data_error_flag,
  output logic [NCPU-1:0] cpu_ready_flags,
  output logic cpu1_resetting_flag,
  output logic [NCPU-1:0] cpu_hold_reset,
  output logic irq
);
  ssf_cond_t cond_s;
  logic [NCPU-1:0] rdy_s;
  logic rst1_s;
  logic [SSF_NSTICKY-1:0] sticky_reg;
  logic [SSF_NSTICKY-1:0] sticky_next;
  logic [1:0] ctrl_reg;
  logic merr_d_reg;
  logic merr_fall;
  logic creq_pulse;
  logic clk_bad;
  logic clk_err_reg;
  logic live_lo_reg;
  logic live_warn_reg;
  logic [NCPU-1:0] rdy_reg;
  logic rst1_reg;
  ssf_clkw_t clkw_reg;
  logic [SSF_NSTICKY-1:0] irq_stat_reg;
  logic [SSF_NSTICKY-1:0] irq_mask_reg;
  logic [SSF_NSTICKY-1:0] sticky_rise;
  logic wr_en;
  logic rd_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] wmask;

  // ==========================================================
  // input synchronisers
  ssf_sync #(.W($bits(ssf_cond_t))) u_sync_cond
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(cond_in),
    .q(cond_s)
  );

  ssf_sync #(.W(NCPU + 1)) u_sync_cpu
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({cpu1_reset_in, cpu_ready_in}),
    .q({rst1_s, rdy_s})
  );

  // ==========================================================
  // apb decode; zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // byte lanes to bit mask
  always_comb
  begin
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = SSF_ZERO;
    unique case (paddr)
      SSF_OFF_STICKY: rd_mux[SSF_NSTICKY-1:0] = sticky_reg;
      SSF_OFF_LIVE: rd_mux[NCPU+3:0] = {rst1_reg, rdy_reg, clk_err_reg, live_warn_reg,
                                        live_lo_reg};
      SSF_OFF_CTRL: rd_mux[1:0] = ctrl_reg;
      SSF_OFF_IRQ_STAT: rd_mux[SSF_NSTICKY-1:0] = irq_stat_reg;
      SSF_OFF_IRQ_MASK: rd_mux[SSF_NSTICKY-1:0] = irq_mask_reg;
      SSF_OFF_CLK_W0: rd_mux[15:0] = clkw_reg.w0;
      SSF_OFF_CLK_W1: rd_mux[15:0] = clkw_reg.w1;
      SSF_OFF_CLK_W2: rd_mux[15:0] = clkw_reg.w2;
      SSF_OFF_CLK_W3: rd_mux[15:0] = clkw_reg.w3;
      default: addr_ok = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error, no side effect
  assign pslverr = psel && penable && !addr_ok;

  // read data captured in the setup cycle so it stands at the access edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= SSF_ZERO;
    else if (rd_setup)
      prdata <= rd_mux;
  end

  // ==========================================================
  // control register: motion error flag and clock check request
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_reg <= 2'b00;
    else if (wr_en && paddr == SSF_OFF_CTRL && pstrb[0])
    begin
      ctrl_reg[SSF_CTRL_MERR] <= pwdata[SSF_CTRL_MERR];
      ctrl_reg[SSF_CTRL_CREQ] <= 1'b0; // request bit self-clears
    end
    else
      ctrl_reg[SSF_CTRL_CREQ] <= 1'b0;
  end

  assign creq_pulse = wr_en && paddr == SSF_OFF_CTRL && pstrb[0] && pwdata[SSF_CTRL_CREQ];

  // falling edge of the motion error flag
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      merr_d_reg <= 1'b0;
    else
      merr_d_reg <= ctrl_reg[SSF_CTRL_MERR];
  end

  assign merr_fall = merr_d_reg && !ctrl_reg[SSF_CTRL_MERR];

  // ==========================================================
  // sticky latches; a new error wins over the clear in the same cycle
  always_comb
  begin
    sticky_next = sticky_reg;
    if (merr_fall)
    begin
      sticky_next[SSF_B_DIAG] = 1'b0;
      sticky_next[SSF_B_SELF] = 1'b0;
    end
    if (cond_s.diag_err)
      sticky_next[SSF_B_DIAG] = 1'b1;
    if (cond_s.self_diag_err)
      sticky_next[SSF_B_SELF] = 1'b1;
    if (cond_s.batt_below_2v5)
      sticky_next[SSF_B_BLOW] = 1'b1;
    if (cond_s.batt_below_2v7)
      sticky_next[SSF_B_BWARN] = 1'b1;
    if (cond_s.ac_dropout)
      sticky_next[SSF_B_DROP] = 1'b1;
    if (cond_s.fuse_blown_any)
      sticky_next[SSF_B_FUSE] = 1'b1;
  end

  // power-on reset returns all latches to zero; a motion error fall also clears the two diagnosis latches
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sticky_reg <= SSF_STICKY_RST;
    else
      sticky_reg <= sticky_next;
  end

  // ==========================================================
  // live flags follow their conditions
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      live_lo_reg <= 1'b0;
      live_warn_reg <= 1'b0;
      rdy_reg <= '0;
      rst1_reg <= 1'b0;
    end
    else
    begin
      live_lo_reg <= cond_s.batt_below_2v5;
      live_warn_reg <= cond_s.batt_below_2v7;
      rdy_reg <= rdy_s;
      rst1_reg <= rst1_s;
    end
  end

  // ==========================================================
  // clock data words and check on request
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      clkw_reg <= '0;
    else if (wr_en)
    begin
      if (paddr == SSF_OFF_CLK_W0)
        clkw_reg.w0 <= (clkw_reg.w0 & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      if (paddr == SSF_OFF_CLK_W1)
        clkw_reg.w1 <= (clkw_reg.w1 & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      if (paddr == SSF_OFF_CLK_W2)
        clkw_reg.w2 <= (clkw_reg.w2 & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      if (paddr == SSF_OFF_CLK_W3)
        clkw_reg.w3 <= (clkw_reg.w3 & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
    end
  end

  ssf_clkchk u_clkchk
  (
    .words(clkw_reg),
    .bad(clk_bad)
  );

  // flag only changes when a request arrives
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      clk_err_reg <= 1'b0;
    else if (creq_pulse)
      clk_err_reg <= clk_bad;
  end

  // ==========================================================
  // interrupt: sticky-latch rises set status, read of status clears
  assign sticky_rise = sticky_next & ~sticky_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_stat_reg <= '0;
    else if (rd_en && paddr == SSF_OFF_IRQ_STAT)
      // only bits already reported clear; a late event is not lost
      irq_stat_reg <= (irq_stat_reg & ~prdata[SSF_NSTICKY-1:0]) | sticky_rise;
    else
      irq_stat_reg <= irq_stat_reg | sticky_rise;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_mask_reg <= '0;
    else if (wr_en && paddr == SSF_OFF_IRQ_MASK && pstrb[0])
      irq_mask_reg <= pwdata[SSF_NSTICKY-1:0];
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // outputs
  assign diag_error_flag = sticky_reg[SSF_B_DIAG];
  assign self_diag_error_flag = sticky_reg[SSF_B_SELF];
  assign batt_low_latch = sticky_reg[SSF_B_BLOW];
  assign batt_warn_latch = sticky_reg[SSF_B_BWARN];
  assign supply_dropout_flag = sticky_reg[SSF_B_DROP];
  assign fuse_blown_flag = sticky_reg[SSF_B_FUSE];
  assign batt_low_live = live_lo_reg;
  assign batt_warn_live = live_warn_reg;
  assign clock_data_error_flag = clk_err_reg;
  assign cpu_ready_flags = rdy_reg;
  assign cpu1_resetting_flag = rst1_reg;
  // cpu one is itself reset externally; the others are held from here
  assign cpu_hold_reset = {{(NCPU-1){rst1_reg}}, 1'b0};

  // ==========================================================
  // checks
  diag_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    diag_error_flag && !merr_fall |=> diag_error_flag)
    else $error("diagnosis flag dropped without clear");
  diag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond_s.diag_err |=> diag_error_flag)
    else $error("diagnosis flag not set");
  self_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond_s.self_diag_err |=> self_diag_error_flag)
    else $error("self diagnosis flag not set");
  merr_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    merr_fall && !cond_s.diag_err && !cond_s.self_diag_err
    |=> !diag_error_flag && !self_diag_error_flag)
    else $error("motion error fall did not clear");
  blow_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond_s.batt_below_2v5 |=> batt_low_latch && batt_low_live)
    else $error("battery low not set");
  blow_live_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cond_s.batt_below_2v5 |=> !batt_low_live)
    else $error("live battery low stuck");
  warn_live_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(cond_s.batt_below_2v7) |=> !batt_warn_live && batt_warn_latch)
    else $error("battery warn flags wrong");
  warn_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond_s.batt_below_2v7 |=> batt_warn_live)
    else $error("live battery warn missing");
  drop_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    supply_dropout_flag |=> supply_dropout_flag)
    else $error("dropout flag cleared");
  fuse_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond_s.fuse_blown_any |=> fuse_blown_flag [*2])
    else $error("fuse flag not held");
  clk_chk_a: assert property (@(posedge clk) disable iff (sys_rst)
    creq_pulse |=> clock_data_error_flag == $past(clk_bad))
    else $error("clock check result wrong");
  clk_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !creq_pulse |=> $stable(clock_data_error_flag))
    else $error("clock flag moved without request");
  rdy_a: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> cpu_ready_flags == $past(rdy_s))
    else $error("ready flags lag");
  rst1_a: assert property (@(posedge clk) disable iff (sys_rst)
    rst1_s |=> cpu1_resetting_flag && (&cpu_hold_reset[NCPU-1:1]))
    else $error("cpu one reset not reflected");
  hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cpu1_resetting_flag |-> cpu_hold_reset == '0)
    else $error("other cpus held without cause");
  irq_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    sticky_rise != '0 |=> (irq_stat_reg & $past(sticky_rise)) == $past(sticky_rise))
    else $error("latch event missing from irq status");

  diag_clear_c: cover property (@(posedge clk) disable iff (sys_rst)
    diag_error_flag ##1 merr_fall ##1 !diag_error_flag);
  batt_recover_c: cover property (@(posedge clk) disable iff (sys_rst)
    batt_low_live ##[1:20] !batt_low_live && batt_low_latch);
  clk_err_c: cover property (@(posedge clk) disable iff (sys_rst)
    creq_pulse && clk_bad);
  irq_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
endmodule : ssf_bank

// File: ssf_bank_tb.sv
// Purpose: self-checking bench for the system status flag bank
// Assumes: zero-wait APB slave, flags follow condition inputs within three edges
// Notes: one task per scenario, only mismatches and the verdict are printed
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
  import ssf_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ssf_cond_t cond_in = '0;
  logic [3:0] cpu_ready_in = 4'h0;
  logic cpu1_reset_in = 1'b0;
  logic diag_error_flag, self_diag_error_flag, batt_low_latch, batt_low_live;
  logic batt_warn_latch, batt_warn_live, supply_dropout_flag, fuse_blown_flag;
  logic clock_data_error_flag, cpu1_resetting_flag, irq;
  logic [3:0] cpu_ready_flags;
  logic [3:0] cpu_hold_reset;
  logic [5:0] sticky_o;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int n_compared = 0;
  // sticky outputs in register bit order, diag at bit 0
  assign sticky_o = {fuse_blown_flag, supply_dropout_flag, batt_warn_latch,
                     batt_low_latch, self_diag_error_flag, diag_error_flag};
  // 250 MHz
  always #2 clk = ~clk;
  ssf_bank #(.NCPU(4)) dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cond_in(cond_in), .cpu_ready_in(cpu_ready_in),
    .cpu1_reset_in(cpu1_reset_in), .diag_error_flag(diag_error_flag),
    .self_diag_error_flag(self_diag_error_flag), .batt_low_latch(batt_low_latch),
    .batt_low_live(batt_low_live), .batt_warn_latch(batt_warn_latch),
    .batt_warn_live(batt_warn_live), .supply_dropout_flag(supply_dropout_flag),
    .fuse_blown_flag(fuse_blown_flag), .clock_data_error_flag(clock_data_error_flag),
    .cpu_ready_flags(cpu_ready_flags), .cpu1_resetting_flag(cpu1_resetting_flag),
    .cpu_hold_reset(cpu_hold_reset), .irq(irq));
  // ==========================================================
  // shared tasks
  task automatic results();
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // settle a fixed count of edges, then step past the update region
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= {4{wr}};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    // answer taken at the very edge where pready is seen high
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    if (i == 16)
    begin
      err_count++;
      results();
    end
  endtask : apb
  // ==========================================================
  // scenarios
  task automatic t_reset();
    `CHK(sticky_o, 6'h00)
    apb(1'b0, SSF_OFF_STICKY, 32'h0);
    `CHK(rd[5:0], 6'h00)
  endtask : t_reset
  // each condition pulsed alone; latch must outlive it, live flags must not
  task automatic t_sticky();
    logic [5:0] exp;
    exp = 6'h00;
    apb(1'b1, SSF_OFF_IRQ_MASK, 32'h0000_003E);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      cond_in <= ssf_cond_t'(6'h20 >> i);
      cyc(4);
      if (i == 2) `CHK(batt_low_live, 1'b1)
      if (i == 3) `CHK(batt_warn_live, 1'b1)
      @(posedge clk);
      cond_in <= '0;
      cyc(4);
      exp[i] = 1'b1;
      `CHK(sticky_o, exp)
      `CHK(irq, (i > 0)) // diag event is masked
      `CHK({batt_warn_live, batt_low_live}, 2'b00)
    end
    // read-only write is ignored
    apb(1'b1, SSF_OFF_STICKY, 32'h0);
    apb(1'b0, SSF_OFF_STICKY, 32'h0);
    `CHK(rd[5:0], 6'h3F)
    apb(1'b0, SSF_OFF_IRQ_STAT, 32'h0);
    `CHK(rd[5:0], 6'h3F)
    apb(1'b0, SSF_OFF_IRQ_STAT, 32'h0);
    `CHK(rd[5:0], 6'h00)
    `CHK(irq, 1'b0)
  endtask : t_sticky
  // only the falling motion error flag clears the two diagnosis latches
  task automatic t_merr_clear();
    apb(1'b1, SSF_OFF_CTRL, 32'h0000_0001);
    cyc(4);
    `CHK(sticky_o, 6'h3F)
    apb(1'b1, SSF_OFF_CTRL, 32'h0000_0000);
    cyc(4);
    `CHK(sticky_o, 6'h3C)
  endtask : t_merr_clear
  // boundary values of each checked field, and two sets with two bad fields each
  task automatic t_clock();
    logic [15:0] w1 [4] = '{16'h0C1F, 16'h0D01, 16'h0100, 16'h0101};
    logic [15:0] w2 [4] = '{16'h173B, 16'h173B, 16'h183B, 16'h0000};
    logic [15:0] w3 [4] = '{16'h3B06, 16'h3B07, 16'h0000, 16'h0000};
    logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, SSF_OFF_CLK_W0, 32'h0000_07E8);
      apb(1'b1, SSF_OFF_CLK_W1, {16'h0, w1[i]});
      apb(1'b1, SSF_OFF_CLK_W2, {16'h0, w2[i]});
      apb(1'b1, SSF_OFF_CLK_W3, {16'h0, w3[i]});
      apb(1'b1, SSF_OFF_CTRL, 32'h0000_0002);
      cyc(2);
      `CHK(clock_data_error_flag, ex[i])
      apb(1'b0, SSF_OFF_LIVE, 32'h0);
      `CHK(rd[2], ex[i])
    end
  endtask : t_clock
  task automatic t_cpu();
    @(posedge clk);
    cpu_ready_in <= 4'b1010;
    cyc(4);
    `CHK(cpu_ready_flags, 4'b1010)
    @(posedge clk);
    cpu_ready_in <= 4'b0101;
    cyc(4);
    `CHK(cpu_ready_flags, 4'b0101)
    @(posedge clk);
    cpu1_reset_in <= 1'b1;
    cyc(4);
    `CHK(cpu1_resetting_flag, 1'b1)
    `CHK(cpu_hold_reset, 4'b1110)
    apb(1'b0, SSF_OFF_LIVE, 32'h0);
    `CHK({rd[7], rd[6:3]}, 5'b10101)
    @(posedge clk);
    cpu1_reset_in <= 1'b0;
    cyc(4);
    `CHK(cpu1_resetting_flag, 1'b0)
    `CHK(cpu_hold_reset, 4'b0000)
  endtask : t_cpu
  task automatic t_unmapped();
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, SSF_ZERO)
  endtask : t_unmapped
  // a power cycle is the only way out of the dropout latch
  task automatic t_power_cycle();
    `CHK(supply_dropout_flag, 1'b1)
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(1);
    `CHK(supply_dropout_flag, 1'b0)
    `CHK(sticky_o, 6'h00)
  endtask : t_power_cycle
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(1);
    t_reset();
    t_sticky();
    t_merr_clear();
    t_clock();
    t_cpu();
    t_unmapped();
    t_power_cycle();
    results();
  end
endmodule : testbench
